// >>> pkg/aobc_pkg.sv
// constants for the buffer-count counter control block
package aobc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CNT_W  = 24;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_GRP_B_ACK     = 8'h03;
  localparam logic [7:0] IDX_OUT_STATUS_1  = 8'h03;
  localparam logic [7:0] IDX_OUT_CMD_2     = 8'h05;
  localparam logic [7:0] IDX_OUT_STATUS_2  = 8'h06;
  localparam logic [7:0] IDX_OUT_CMD_1     = 8'h09;
  localparam logic [7:0] IDX_SAVE_HIGH     = 8'h12;
  localparam logic [7:0] IDX_SAVE_LOW      = 8'h13;
  localparam logic [7:0] IDX_JOINT_STATUS  = 8'h1b;
  localparam logic [7:0] IDX_OUT_MODE_2    = 8'h27;
  localparam logic [7:0] IDX_LOAD_A_HIGH   = 8'h2c;
  localparam logic [7:0] IDX_LOAD_A_LOW    = 8'h2d;
  localparam logic [7:0] IDX_LOAD_B_HIGH   = 8'h2e;
  localparam logic [7:0] IDX_LOAD_B_LOW    = 8'h2f;
  localparam logic [7:0] IDX_START_SELECT  = 8'h42;
  localparam logic [7:0] IDX_PERSONAL      = 8'h4e;

  // command one
  localparam int unsigned BIT_HYST_CLEAR   = 15;
  localparam int unsigned BIT_DISARM       = 13;
  localparam int unsigned BIT_ARM          = 6;
  localparam int unsigned BIT_LOAD         = 5;
  // command two
  localparam int unsigned BIT_GATE_ENABLE  = 11;
  localparam int unsigned BIT_SNAP_FREEZE  = 10;
  localparam int unsigned BIT_SWAP_STROBE  = 4;
  // group b acknowledge
  localparam int unsigned BIT_TC_ACK       = 8;
  localparam int unsigned BIT_ERR_CLEAR    = 4;
  // status one / two, joint status
  localparam int unsigned BIT_TC_ERROR     = 11;
  localparam int unsigned BIT_ARMED        = 0;
  localparam int unsigned BIT_NEXT_PRESET  = 1;
  localparam int unsigned BIT_SNAP_HELD    = 2;
  localparam int unsigned BIT_CTRL_STATE   = 3;
  localparam int unsigned BIT_GATE_FLAG    = 6;
  // mode two
  localparam int unsigned BIT_FIRST_LOAD   = 2;
  localparam int unsigned BIT_AUTO_SWAP    = 1;
  // start select, personalization
  localparam int unsigned BIT_FREQ_ENABLE  = 12;
  localparam int unsigned BIT_FREQ_POL     = 9;
  localparam int unsigned BIT_SRC_CHOICE   = 4;

  localparam logic [1:0]       RESP_OKAY    = 2'h0;
  localparam logic [1:0]       RESP_SLVERR  = 2'h2;
  localparam logic [15:0]      RST_REG16    = 16'h0000;
  localparam logic [CNT_W-1:0] RST_CNT      = 24'h000000;
  // source choice resets to the supported setting
  localparam logic             RST_SRC      = 1'b1;

  typedef enum logic [0:0] {
    AOBC_WAIT  = 1'b0,
    AOBC_COUNT = 1'b1
  } aobc_state_e;
endpackage : aobc_pkg

// >>> rtl/aobc_counter_ctrl.sv
// buffer-count counter control with its axi4-lite register slave
// Behaviour
// - secondary group raises timing interrupt only on secondary interval terminal, in group B.
// - writing hysteresis clear bit 15 clears trigger hysteresis and self-clears.
// - frequency enable 0 forces frequency pin to inactive level per polarity.
// - frequency polarity 0 is active high, 1 is active low.
// - arm bit 6 arms counter until hardware or disarm command disarms it.
// - armed flag reads 1 while armed, 0 while disarmed.
// - gate enable 1 passes external updates only while counter is counting.
// - gate flag shows blocked 0 or passing 1 while gate enabled.
// - first load select picks preset A or B only while disarmed.
// - load strobe copies selected preset into counter only while disarmed.
// - presets load on load command and terminal count; high byte at lower index.
// - next preset flag shows A or B and changes on a reload that swaps presets and on a first load select write while disarmed.
// - control state flag reads 0 waiting, 1 counting.
// - auto swap 1 swaps preset every terminal count; 0 swaps only when a swap strobe is pending.
// - snapshot freeze 1 latches at next counter event; 0 follows counter.
// - snapshot held flag reads 0 while following, 1 once latched.
// - snapshot latched on counter source; high byte at lower index.
// - source choice 0 update pulses, 1 update-count terminal; software uses 1.
// - swap strobe makes counter swap presets at next terminal count.
// - terminal error sets on two terminal counts without acknowledge between.
// - error clear bit 4 of group B acknowledge clears terminal error.
// - disarm strobe bit 13 disarms buffer, update-count and interval counters.
`timescale 1ns/100ps
module aobc_counter_ctrl (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         clk_en,
  input  wire logic [aobc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [aobc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         update_pulse,
  input  wire logic                         update_count_terminal,
  input  wire logic                         start_trigger,
  input  wire logic                         hw_disarm,
  input  wire logic                         external_update,
  input  wire logic                         freq_source,
  input  wire logic                         secondary_interval_terminal,
  output logic                              gated_update,
  output logic                              output_frequency_pin,
  output logic                              buffer_terminal_count,
  output logic                              trigger_hysteresis_clear,
  output logic                              counters_disarm_strobe,
  output logic                              group_b_interval_event
);
  localparam int unsigned CW = aobc_pkg::CNT_W;

  function automatic logic [7:0] reg_index(input logic [aobc_pkg::ADDR_W-1:0] a);
    reg_index = a[9:2];
  endfunction : reg_index

  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [3:0] strb);
    logic [15:0] m;
    m       = {{8{strb[1]}}, {8{strb[0]}}};
    merge16 = (old_v & ~m) | (new_v & m);
  endfunction : merge16

  // bus state
  logic                        aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [7:0]                  aw_idx_q, aw_idx_d;
  logic [15:0]                 wdata_q, wdata_d;
  logic [3:0]                  wstrb_q, wstrb_d;
  logic                        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]                  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]                 rdata_q, rdata_d;
  logic                        do_write;
  logic [15:0]                 wbits;
  // control state
  logic [15:0]                 cmd2_q, cmd2_d, mode2_q, mode2_d;
  logic [15:0]                 start_sel_q, start_sel_d, personal_q, personal_d;
  logic [CW-1:0]               preset_a_q, preset_a_d, preset_b_q, preset_b_d;
  logic [CW-1:0]               count_q, count_d;
  logic [CW-1:0]               snap_q, snap_d;
  logic                        snap_held_q, snap_held_d, armed_q, armed_d, sel_q, sel_d;
  logic                        swap_pend_q, swap_pend_d, tc_unacked_q, tc_unacked_d, tc_error_q, tc_error_d;
  aobc_pkg::aobc_state_e       state_q, state_d;
  logic                        gated_q, gated_d, freq_q, freq_d, tc_q, tc_d;
  logic                        hyst_q, hyst_d, disarm_out_q, disarm_out_d, irq_b_q, irq_b_d;
  logic                        src_evt, counting, tc_now, gate_open, swap_sel;
  logic                        wr_cmd1, wr_cmd2, wr_ack, wr_mode2;

  assign s_axi_awready = clk_en & ~aw_full_q & ~bvalid_q;
  assign s_axi_wready  = clk_en & ~w_full_q & ~bvalid_q;
  assign s_axi_arready = clk_en & ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  assign do_write = aw_full_q & w_full_q & ~bvalid_q;
  // strobes only act on the byte lanes that were enabled
  assign wbits    = wdata_q & {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_cmd1  = do_write & (aw_idx_q == aobc_pkg::IDX_OUT_CMD_1);
  assign wr_cmd2  = do_write & (aw_idx_q == aobc_pkg::IDX_OUT_CMD_2);
  assign wr_ack   = do_write & (aw_idx_q == aobc_pkg::IDX_GRP_B_ACK);
  assign wr_mode2 = do_write & (aw_idx_q == aobc_pkg::IDX_OUT_MODE_2);

  always_comb
  begin
    aw_full_d = aw_full_q;
    aw_idx_d  = aw_idx_q;
    w_full_d  = w_full_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_d = 1'b1;
      aw_idx_d  = reg_index(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_d = 1'b1;
      wdata_d  = s_axi_wdata[15:0];
      wstrb_d  = s_axi_wstrb;
    end
    if (do_write)
    begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      unique case (aw_idx_q)
        aobc_pkg::IDX_GRP_B_ACK, aobc_pkg::IDX_OUT_CMD_2, aobc_pkg::IDX_OUT_CMD_1,
        aobc_pkg::IDX_OUT_MODE_2, aobc_pkg::IDX_LOAD_A_HIGH, aobc_pkg::IDX_LOAD_A_LOW,
        aobc_pkg::IDX_LOAD_B_HIGH, aobc_pkg::IDX_LOAD_B_LOW, aobc_pkg::IDX_START_SELECT,
        aobc_pkg::IDX_PERSONAL:
          bresp_d = aobc_pkg::RESP_OKAY;
        default:
          bresp_d = aobc_pkg::RESP_SLVERR;
      endcase
    end
    else if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d  = aobc_pkg::RESP_OKAY;
      rdata_d  = 32'h00000000;
      unique case (reg_index(s_axi_araddr))
        aobc_pkg::IDX_OUT_STATUS_1:
          rdata_d[aobc_pkg::BIT_TC_ERROR] = tc_error_q;
        aobc_pkg::IDX_OUT_STATUS_2:
        begin
          rdata_d[aobc_pkg::BIT_ARMED]       = armed_q;
          rdata_d[aobc_pkg::BIT_NEXT_PRESET] = sel_q;
          rdata_d[aobc_pkg::BIT_SNAP_HELD]   = snap_held_q;
          rdata_d[aobc_pkg::BIT_CTRL_STATE]  = state_q;
        end
        aobc_pkg::IDX_SAVE_HIGH:
          rdata_d[7:0] = snap_q[CW-1:16];
        aobc_pkg::IDX_SAVE_LOW:
          rdata_d[15:0] = snap_q[15:0];
        aobc_pkg::IDX_JOINT_STATUS:
          rdata_d[aobc_pkg::BIT_GATE_FLAG] = gate_open;
        aobc_pkg::IDX_OUT_CMD_2, aobc_pkg::IDX_OUT_CMD_1, aobc_pkg::IDX_OUT_MODE_2,
        aobc_pkg::IDX_LOAD_A_HIGH, aobc_pkg::IDX_LOAD_A_LOW, aobc_pkg::IDX_LOAD_B_HIGH,
        aobc_pkg::IDX_LOAD_B_LOW, aobc_pkg::IDX_START_SELECT, aobc_pkg::IDX_PERSONAL:
          rdata_d = 32'h00000000;
        default:
          rresp_d = aobc_pkg::RESP_SLVERR;
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      aw_idx_q  <= 8'h00;
      w_full_q  <= 1'b0;
      wdata_q   <= aobc_pkg::RST_REG16;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= aobc_pkg::RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= aobc_pkg::RESP_OKAY;
      rdata_q   <= 32'h00000000;
    end
    else if (clk_en)
    begin
      aw_full_q <= aw_full_d;
      aw_idx_q  <= aw_idx_d;
      w_full_q  <= w_full_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // counter source: the unsupported update-pulse setting is still wired
  assign src_evt   = personal_q[aobc_pkg::BIT_SRC_CHOICE] ? update_count_terminal : update_pulse;
  assign counting  = (state_q == aobc_pkg::AOBC_COUNT);
  assign tc_now    = counting & src_evt & (count_q == aobc_pkg::RST_CNT);
  // only counting opens the gate; software keeps it off for internal updates
  assign gate_open = cmd2_q[aobc_pkg::BIT_GATE_ENABLE] & counting;
  assign swap_sel  = sel_q ^ (mode2_q[aobc_pkg::BIT_AUTO_SWAP] | swap_pend_q);

  always_comb
  begin
    cmd2_d       = cmd2_q;
    mode2_d      = mode2_q;
    start_sel_d  = start_sel_q;
    personal_d   = personal_q;
    preset_a_d   = preset_a_q;
    preset_b_d   = preset_b_q;
    count_d      = count_q;
    snap_d       = snap_q;
    snap_held_d  = snap_held_q;
    armed_d      = armed_q;
    sel_d        = sel_q;
    swap_pend_d  = swap_pend_q;
    tc_unacked_d = tc_unacked_q;
    tc_error_d   = tc_error_q;
    state_d      = state_q;
    if (do_write)
    begin
      unique case (aw_idx_q)
        aobc_pkg::IDX_OUT_CMD_2:    cmd2_d = merge16(cmd2_q, wdata_q, wstrb_q);
        aobc_pkg::IDX_START_SELECT: start_sel_d = merge16(start_sel_q, wdata_q, wstrb_q);
        aobc_pkg::IDX_PERSONAL:     personal_d = merge16(personal_q, wdata_q, wstrb_q);
        aobc_pkg::IDX_LOAD_A_HIGH:  preset_a_d[CW-1:16] = wstrb_q[0] ? wdata_q[7:0] : preset_a_q[CW-1:16];
        aobc_pkg::IDX_LOAD_A_LOW:   preset_a_d[15:0] = merge16(preset_a_q[15:0], wdata_q, wstrb_q);
        aobc_pkg::IDX_LOAD_B_HIGH:  preset_b_d[CW-1:16] = wstrb_q[0] ? wdata_q[7:0] : preset_b_q[CW-1:16];
        aobc_pkg::IDX_LOAD_B_LOW:   preset_b_d[15:0] = merge16(preset_b_q[15:0], wdata_q, wstrb_q);
        default:                    cmd2_d = cmd2_q;
      endcase
    end
    // mode two is held whole, but the first load choice only takes while disarmed
    if (wr_mode2)
    begin
      mode2_d = merge16(mode2_q, wdata_q, wstrb_q);
      if (armed_q)
        mode2_d[aobc_pkg::BIT_FIRST_LOAD] = mode2_q[aobc_pkg::BIT_FIRST_LOAD];
      else
        sel_d = mode2_d[aobc_pkg::BIT_FIRST_LOAD];
    end
    if (wr_cmd1 && wbits[aobc_pkg::BIT_LOAD] && !armed_q)
      count_d = sel_d ? preset_b_q : preset_a_q;
    // terminal count reloads on the same edge, so no count is lost
    if (tc_now)
    begin
      sel_d   = swap_sel;
      count_d = swap_sel ? preset_b_q : preset_a_q;
    end
    else if (counting && src_evt)
    begin
      count_d = count_q - 24'h000001;
    end
    // a strobe in the terminal cycle waits for the following terminal count
    if (tc_now)
      swap_pend_d = 1'b0;
    if (wr_cmd2 && wbits[aobc_pkg::BIT_SWAP_STROBE])
      swap_pend_d = 1'b1;
    if (wr_cmd1 && wbits[aobc_pkg::BIT_ARM])
      armed_d = 1'b1;
    if ((wr_cmd1 && wbits[aobc_pkg::BIT_DISARM]) || hw_disarm)
      armed_d = 1'b0;
    unique case (state_q)
      aobc_pkg::AOBC_WAIT:
        if (armed_q && start_trigger)
          state_d = aobc_pkg::AOBC_COUNT;
      aobc_pkg::AOBC_COUNT:
        if (!armed_d)
          state_d = aobc_pkg::AOBC_WAIT;
    endcase
    if (!cmd2_q[aobc_pkg::BIT_SNAP_FREEZE])
    begin
      snap_held_d = 1'b0;
      snap_d      = count_q;
    end
    else if (!snap_held_q && src_evt)
    begin
      snap_held_d = 1'b1;
      snap_d      = count_q;
    end
    if (wr_ack && wbits[aobc_pkg::BIT_TC_ACK])
      tc_unacked_d = 1'b0;
    if (wr_ack && wbits[aobc_pkg::BIT_ERR_CLEAR])
      tc_error_d = 1'b0;
    // set wins over the acknowledge and the clear in the same cycle
    if (tc_now)
    begin
      tc_unacked_d = 1'b1;
      if (tc_unacked_q && !(wr_ack && wbits[aobc_pkg::BIT_TC_ACK]))
        tc_error_d = 1'b1;
    end
  end

  always_comb
  begin
    gated_d = cmd2_q[aobc_pkg::BIT_GATE_ENABLE] ? (external_update & gate_open) : external_update;
    // disabled pin rests at the polarity bit, its inactive level
    freq_d = start_sel_q[aobc_pkg::BIT_FREQ_ENABLE] ?
             (freq_source ^ personal_q[aobc_pkg::BIT_FREQ_POL]) :
             personal_q[aobc_pkg::BIT_FREQ_POL];
    tc_d         = tc_now;
    hyst_d       = wr_cmd1 & wbits[aobc_pkg::BIT_HYST_CLEAR];
    disarm_out_d = wr_cmd1 & wbits[aobc_pkg::BIT_DISARM];
    irq_b_d      = secondary_interval_terminal;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd2_q       <= aobc_pkg::RST_REG16;
      mode2_q      <= aobc_pkg::RST_REG16;
      start_sel_q  <= aobc_pkg::RST_REG16;
      personal_q   <= {11'h000, aobc_pkg::RST_SRC, 4'h0};
      preset_a_q   <= aobc_pkg::RST_CNT;
      preset_b_q   <= aobc_pkg::RST_CNT;
      count_q      <= aobc_pkg::RST_CNT;
      snap_q       <= aobc_pkg::RST_CNT;
      snap_held_q  <= 1'b0;
      armed_q      <= 1'b0;
      sel_q        <= 1'b0;
      swap_pend_q  <= 1'b0;
      tc_unacked_q <= 1'b0;
      tc_error_q   <= 1'b0;
      state_q      <= aobc_pkg::AOBC_WAIT;
      gated_q      <= 1'b0;
      freq_q       <= 1'b0;
      tc_q         <= 1'b0;
      hyst_q       <= 1'b0;
      disarm_out_q <= 1'b0;
      irq_b_q      <= 1'b0;
    end
    else if (clk_en)
    begin
      cmd2_q       <= cmd2_d;
      mode2_q      <= mode2_d;
      start_sel_q  <= start_sel_d;
      personal_q   <= personal_d;
      preset_a_q   <= preset_a_d;
      preset_b_q   <= preset_b_d;
      count_q      <= count_d;
      snap_q       <= snap_d;
      snap_held_q  <= snap_held_d;
      armed_q      <= armed_d;
      sel_q        <= sel_d;
      swap_pend_q  <= swap_pend_d;
      tc_unacked_q <= tc_unacked_d;
      tc_error_q   <= tc_error_d;
      state_q      <= state_d;
      gated_q      <= gated_d;
      freq_q       <= freq_d;
      tc_q         <= tc_d;
      hyst_q       <= hyst_d;
      disarm_out_q <= disarm_out_d;
      irq_b_q      <= irq_b_d;
    end
  end

  assign gated_update             = gated_q;
  assign output_frequency_pin     = freq_q;
  assign buffer_terminal_count    = tc_q;
  assign trigger_hysteresis_clear = hyst_q;
  assign counters_disarm_strobe   = disarm_out_q;
  assign group_b_interval_event   = irq_b_q;
endmodule : aobc_counter_ctrl

// >>> test/aobc_checker.sv
// port-level assertions for the buffer-count control block
`timescale 1ns/100ps
module aobc_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic update_pulse,
  input wire logic update_count_terminal,
  input wire logic external_update,
  input wire logic secondary_interval_terminal,
  input wire logic gated_update,
  input wire logic buffer_terminal_count,
  input wire logic trigger_hysteresis_clear,
  input wire logic counters_disarm_strobe,
  input wire logic group_b_interval_event
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_b_after; s_wr_both |-> ##[1:3] s_axi_bvalid; endproperty
  a_b_after: assert property (p_b_after) else $error("write response late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_aw_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("write taken during response");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_grp_b; group_b_interval_event |-> $past(secondary_interval_terminal); endproperty
  a_grp_b: assert property (p_grp_b) else $error("group b event without cause");
  property p_hyst; trigger_hysteresis_clear |=> !trigger_hysteresis_clear; endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis clear stuck");
  property p_disarm; counters_disarm_strobe |=> !counters_disarm_strobe; endproperty
  a_disarm: assert property (p_disarm) else $error("disarm strobe stuck");
  property p_gate; gated_update |-> $past(external_update) && !$past(s_axi_rvalid && s_axi_arvalid); endproperty
  a_gate: assert property (p_gate) else $error("update passed without input");
  property p_tc;
    buffer_terminal_count |-> $past(update_pulse || update_count_terminal, 2) || $past(update_count_terminal);
  endproperty
  a_tc: assert property (p_tc) else $error("terminal count without source event");
endmodule : aobc_checker
bind aobc_counter_ctrl aobc_checker chk_u (.*);

// >>> test/testbench.sv
// self-checking bench for the buffer-count control block
`timescale 1ns/100ps
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1;
  logic [aobc_pkg::ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, update_pulse = 1'b0, freq_source = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rv;
  logic gated_update, output_frequency_pin, buffer_terminal_count;
  logic trigger_hysteresis_clear, counters_disarm_strobe, group_b_interval_event;
  // one-cycle event inputs: start, hw disarm, external update, interval, source
  logic [4:0] pv = 5'h00;
  wire start_trigger = pv[0];
  wire hw_disarm = pv[1];
  wire external_update = pv[2];
  wire secondary_interval_terminal = pv[3];
  wire update_count_terminal = pv[4];
  int bad_count = 0, num_checks = 0, tc_n = 0, hy_n = 0, ds_n = 0, gt_n = 0, ib_n = 0;

  aobc_counter_ctrl dut_u (.*);

  initial
  begin
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    tc_n <= tc_n + buffer_terminal_count;
    hy_n <= hy_n + trigger_hysteresis_clear;
    ds_n <= ds_n + counters_disarm_strobe;
    gt_n <= gt_n + gated_update;
    ib_n <= ib_n + group_b_interval_event;
  end

  task automatic close_out;
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask : chk

  // the leading edge keeps a ready release and the next raise apart
  task automatic wr(input logic [7:0] i, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 40);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 40)
    begin
      chk("write timeout", 32'h1, 32'h0);
      close_out();
    end
  endtask : wr

  task automatic rd(input logic [7:0] i);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 40);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 40)
    begin
      chk("read timeout", 32'h1, 32'h0);
      close_out();
    end
  endtask : rd

  task automatic pu(input int b);
    pv[b] <= 1'b1;
    @(posedge aclk);
    pv[b] <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : pu

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(aobc_pkg::IDX_OUT_STATUS_2);
    chk("status two", rv, 32'h0);
    rd(8'h7f);
    chk("unmapped", {rv[29:0], rs}, {30'h0, aobc_pkg::RESP_SLVERR});
    wr(aobc_pkg::IDX_SAVE_LOW, 16'hffff);
    chk("ro write", {30'h0, rs}, {30'h0, aobc_pkg::RESP_SLVERR});
    for (int k = 0; k < 4; k++)
    begin
      wr(aobc_pkg::IDX_PERSONAL, 16'h0010 | (16'(k[1]) << 9));
      wr(aobc_pkg::IDX_START_SELECT, 16'(k[0]) << 12);
      freq_source <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("freq pin", {31'h0, output_frequency_pin}, {31'h0, k[0] ? ~k[1] : k[1]});
    end
    wr(aobc_pkg::IDX_LOAD_A_LOW, 16'h0002);
    wr(aobc_pkg::IDX_LOAD_B_HIGH, 16'h0001);
    wr(aobc_pkg::IDX_LOAD_B_LOW, 16'h0004);
    wr(aobc_pkg::IDX_OUT_MODE_2, 16'h0004);
    wr(aobc_pkg::IDX_OUT_CMD_1, 16'h0020);
    rd(aobc_pkg::IDX_SAVE_HIGH);
    chk("save high", rv, 32'h1);
    rd(aobc_pkg::IDX_SAVE_LOW);
    chk("save low b", rv, 32'h4);
    wr(aobc_pkg::IDX_OUT_MODE_2, 16'h0000);
    wr(aobc_pkg::IDX_OUT_CMD_1, 16'h0020);
    wr(aobc_pkg::IDX_OUT_CMD_1, 16'h0040);
    // armed: select and load strobe must both be ignored
    wr(aobc_pkg::IDX_OUT_MODE_2, 16'h0004);
    wr(aobc_pkg::IDX_LOAD_A_LOW, 16'h0003);
    wr(aobc_pkg::IDX_OUT_CMD_1, 16'h0020);
    rd(aobc_pkg::IDX_SAVE_LOW);
    chk("armed load", rv, 32'h2);
    rd(aobc_pkg::IDX_OUT_STATUS_2);
    chk("armed", rv, 32'h1);
    wr(aobc_pkg::IDX_OUT_CMD_2, 16'h0800);
    pu(2);
    rd(aobc_pkg::IDX_JOINT_STATUS);
    chk("gate closed", rv, 32'h0);
    pu(0);
    rd(aobc_pkg::IDX_OUT_STATUS_2);
    chk("counting", rv, 32'h9);
    rd(aobc_pkg::IDX_JOINT_STATUS);
    chk("gate open", rv, 32'h40);
    pu(2);
    chk("gated", 32'(gt_n), 32'h1);
    // frozen: a source event while the enable is low is lost
    clk_en <= 1'b0;
    pu(4);
    clk_en <= 1'b1;
    rd(aobc_pkg::IDX_SAVE_LOW);
    chk("frozen count", rv, 32'h2);
    repeat (3) pu(4);
    rd(aobc_pkg::IDX_OUT_STATUS_1);
    chk("no error", rv & 32'h800, 32'h0);
    repeat (4) pu(4);
    chk("tc count", 32'(tc_n), 32'h2);
    rd(aobc_pkg::IDX_OUT_STATUS_1);
    chk("error", rv & 32'h800, 32'h800);
    rd(aobc_pkg::IDX_OUT_STATUS_2);
    chk("no swap", rv, 32'h9);
    wr(aobc_pkg::IDX_GRP_B_ACK, 16'h0010);
    rd(aobc_pkg::IDX_OUT_STATUS_1);
    chk("error clear", rv & 32'h800, 32'h0);
    wr(aobc_pkg::IDX_GRP_B_ACK, 16'h0100);
    wr(aobc_pkg::IDX_OUT_CMD_2, 16'h0810);
    repeat (4) pu(4);
    rd(aobc_pkg::IDX_OUT_STATUS_2);
    chk("swapped", rv, 32'hb);
    rd(aobc_pkg::IDX_SAVE_HIGH);
    chk("reload b", rv, 32'h1);
    rd(aobc_pkg::IDX_OUT_STATUS_1);
    chk("acked", rv & 32'h800, 32'h0);
    wr(aobc_pkg::IDX_OUT_CMD_2, 16'h0c00);
    pu(4);
    rd(aobc_pkg::IDX_OUT_STATUS_2);
    chk("held", rv, 32'hf);
    wr(aobc_pkg::IDX_OUT_CMD_1, 16'h8000);
    wr(aobc_pkg::IDX_OUT_CMD_1, 16'h2000);
    rd(aobc_pkg::IDX_OUT_STATUS_2);
    chk("disarmed", rv, 32'h6);
    chk("hyst pulse", 32'(hy_n), 32'h1);
    chk("disarm pulse", 32'(ds_n), 32'h1);
    pu(3);
    chk("group b", 32'(ib_n), 32'h1);
    wr(aobc_pkg::IDX_OUT_CMD_1, 16'h0040);
    pu(1);
    rd(aobc_pkg::IDX_OUT_STATUS_2);
    chk("hw disarm", rv, 32'h6);
    close_out();
  end
endmodule : testbench
